/* src/acw_control.v */
// Function
// - De-emphasis code: 00 none, 01 44.1 kHz, 10 32 kHz, 11 48 kHz.
// - De-emphasis applies only in single speed; bypassed in dual and quad.
// - Clip manager enable bit turns clip management on or off.
// - Volume clip reduces volume; bass clip removes bass or reduces volume by mode.
// - Three-bit limiter attack rate, reset 001.
// - Four-bit limiter release rate, reset 1010.
// - Input format: I2S, left justified, right 16-bit, right 24-bit.
// - Four-bit channel mix: mute, mono mix, swap; reset 1001.
// - Bridge outputs driven only when bridge enable is 1; resets off.
// - P-channel compensation resets 10000, valid 00000 to 10000.
// - N-channel compensation resets 00000, valid 00000 to 10000.
// - Low-power bit enables auto low power mode.
// - Speed bit selects low/high PWM speed; method bit selects HPWM/RPWM.
// - Volume code is gain in 0.5 dB steps, -94.5 to +25 dB.
// - Last volume code is soft mute at -95 dB.
// - Left volume bits 0-8, right 9-17, same code sequence.
// - Bass level 0 to 15 dB in 1 dB steps.
// - Bass direction 1 boosts, 0 cuts.
// - Bass corner 00 50 Hz, 01 100 Hz, 10 200 Hz.
// - Treble level 0-15 dB; direction 1 boosts, 0 cuts.
// - Treble corner 00 4 kHz, 01 8 kHz, 10 12 kHz.
// - Transfers are 8 preamble bits then 64 word bits, 72 edges.
// - Dither bit adds a small DC offset.
// - Mix code 1001 routes left to left, right to right.
`timescale 1ns/10ps
`default_nettype none
`include "acw_regs.vh"
module acw_control (
  input wire clk,
  input wire rst,
  input wire ser_en_n,
  input wire ser_clk,
  input wire ser_din,
  output wire ser_dout,
  output wire ser_doe_n,
  input wire [1:0] speed_mode,
  input wire vol_clip,
  input wire bass_clip,
  input wire direct_drive,
  input wire bridge_req,
  output reg [63:0] amp_control_word,
  output reg [1:0] emphasis_filter_select,
  output reg deemph_active,
  output reg clip_manager_enable,
  output reg clip_manager_mode,
  output reg clip_reduce_volume,
  output reg clip_remove_bass,
  output reg dither_enable,
  output reg [2:0] attack_rate,
  output reg [3:0] release_rate,
  output reg [1:0] input_format,
  output reg [3:0] channel_mix_select,
  output reg [1:0] left_src,
  output reg [1:0] right_src,
  output reg bridge_drive,
  output reg [4:0] pchan_comp,
  output reg [4:0] nchan_comp,
  output reg auto_lowpower_enable,
  output reg pwm_high_speed,
  output reg pwm_hpwm,
  output wire signed [9:0] left_gain,
  output wire left_soft_mute,
  output wire signed [9:0] right_gain,
  output wire right_soft_mute,
  output reg bass_direction,
  output reg [3:0] bass_level,
  output reg [1:0] bass_corner_sel,
  output reg treble_direction,
  output reg [3:0] treble_level,
  output reg [1:0] treble_corner_sel
);
  wire [63:0] word_wr;
  wire word_wr_stb;
  wire [63:0] reset_word;
  assign reset_word = {1'b0, 1'b0, 1'b0, `ACW_NCOMP_RESET, `ACW_PCOMP_RESET, 1'b0,
    `ACW_MIX_RESET, 2'h0, `ACW_RELEASE_RESET, `ACW_ATTACK_RESET, 5'h00,
    14'h0000, `ACW_VOL_RESET, `ACW_VOL_RESET};

  acw_serial_port u_port (
    .clk(clk),
    .rst(rst),
    .ser_en_n(ser_en_n),
    .ser_clk(ser_clk),
    .ser_din(ser_din),
    .ser_dout(ser_dout),
    .ser_doe_n(ser_doe_n),
    .word_rd(amp_control_word),
    .word_wr(word_wr),
    .word_wr_stb(word_wr_stb)
  );

  // Register update; compensation fields clamped to valid range
  always @(posedge clk) begin
    if (rst) begin
      amp_control_word <= reset_word;
    end else if (word_wr_stb) begin
      amp_control_word <= word_wr;
      if (word_wr[`ACW_PCOMP_LSB+4:`ACW_PCOMP_LSB] > `ACW_COMP_MAX) begin
        amp_control_word[`ACW_PCOMP_LSB+4:`ACW_PCOMP_LSB] <= `ACW_COMP_MAX;
      end
      if (word_wr[`ACW_NCOMP_LSB+4:`ACW_NCOMP_LSB] > `ACW_COMP_MAX) begin
        amp_control_word[`ACW_NCOMP_LSB+4:`ACW_NCOMP_LSB] <= `ACW_COMP_MAX;
      end
    end
  end

  acw_vol_decode u_vol_l (
    .clk(clk),
    .rst(rst),
    .code(amp_control_word[`ACW_VOLL_LSB+8:`ACW_VOLL_LSB]),
    .gain_half_db(left_gain),
    .soft_mute(left_soft_mute)
  );

  acw_vol_decode u_vol_r (
    .clk(clk),
    .rst(rst),
    .code(amp_control_word[`ACW_VOLR_LSB+8:`ACW_VOLR_LSB]),
    .gain_half_db(right_gain),
    .soft_mute(right_soft_mute)
  );

  reg [1:0] next_left_src;
  reg [1:0] next_right_src;
  wire [3:0] mix = amp_control_word[`ACW_MIX_LSB+3:`ACW_MIX_LSB];
  wire cm_en = amp_control_word[`ACW_CLIP_EN_BIT];
  wire cm_mode = amp_control_word[`ACW_CLIP_MODE_BIT];

  // Source codes: 0 mute, 1 left, 2 right, 3 average
  always @* begin
    case (mix[3:2])
      2'h0: next_left_src = 2'h0;
      2'h1: next_left_src = 2'h2;
      2'h2: next_left_src = 2'h1;
      default: next_left_src = 2'h3;
    endcase
    case (mix[1:0])
      2'h0: next_right_src = 2'h0;
      2'h1: next_right_src = 2'h2;
      2'h2: next_right_src = 2'h1;
      default: next_right_src = 2'h3;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      emphasis_filter_select <= 2'h0;
      deemph_active <= 1'b0;
      clip_manager_enable <= 1'b0;
      clip_manager_mode <= 1'b0;
      clip_reduce_volume <= 1'b0;
      clip_remove_bass <= 1'b0;
      dither_enable <= 1'b0;
      attack_rate <= `ACW_ATTACK_RESET;
      release_rate <= `ACW_RELEASE_RESET;
      input_format <= 2'h0;
      channel_mix_select <= `ACW_MIX_RESET;
      left_src <= 2'h1;
      right_src <= 2'h2;
      bridge_drive <= 1'b0;
      pchan_comp <= `ACW_PCOMP_RESET;
      nchan_comp <= `ACW_NCOMP_RESET;
      auto_lowpower_enable <= 1'b0;
      pwm_high_speed <= 1'b0;
      pwm_hpwm <= 1'b0;
      bass_direction <= 1'b0;
      bass_level <= 4'h0;
      bass_corner_sel <= 2'h0;
      treble_direction <= 1'b0;
      treble_level <= 4'h0;
      treble_corner_sel <= 2'h0;
    end else begin
      emphasis_filter_select <= amp_control_word[`ACW_DE_LSB+1:`ACW_DE_LSB];
      deemph_active <= (amp_control_word[`ACW_DE_LSB+1:`ACW_DE_LSB] != 2'h0) &&
        (speed_mode == `ACW_SPEED_SINGLE);
      clip_manager_enable <= cm_en;
      clip_manager_mode <= cm_mode;
      clip_reduce_volume <= cm_en & (vol_clip | (bass_clip & cm_mode));
      clip_remove_bass <= cm_en & bass_clip & ~cm_mode;
      dither_enable <= amp_control_word[`ACW_DITHER_BIT];
      attack_rate <= amp_control_word[`ACW_ATTACK_LSB+2:`ACW_ATTACK_LSB];
      release_rate <= amp_control_word[`ACW_RELEASE_LSB+3:`ACW_RELEASE_LSB];
      input_format <= amp_control_word[`ACW_FMT_LSB+1:`ACW_FMT_LSB];
      channel_mix_select <= mix;
      left_src <= next_left_src;
      right_src <= next_right_src;
      bridge_drive <= direct_drive & bridge_req & amp_control_word[`ACW_HBON_BIT];
      pchan_comp <= amp_control_word[`ACW_PCOMP_LSB+4:`ACW_PCOMP_LSB];
      nchan_comp <= amp_control_word[`ACW_NCOMP_LSB+4:`ACW_NCOMP_LSB];
      auto_lowpower_enable <= amp_control_word[`ACW_ALP_BIT];
      pwm_high_speed <= amp_control_word[`ACW_HSPD_BIT];
      pwm_hpwm <= amp_control_word[`ACW_HPWM_BIT];
      bass_direction <= amp_control_word[`ACW_BDIR_BIT];
      bass_level <= amp_control_word[`ACW_BLVL_LSB+3:`ACW_BLVL_LSB];
      bass_corner_sel <= amp_control_word[`ACW_BCOR_LSB+1:`ACW_BCOR_LSB];
      treble_direction <= amp_control_word[`ACW_TDIR_BIT];
      treble_level <= amp_control_word[`ACW_TLVL_LSB+3:`ACW_TLVL_LSB];
      treble_corner_sel <= amp_control_word[`ACW_TCOR_LSB+1:`ACW_TCOR_LSB];
    end
  end
endmodule
`default_nettype wire

/* src/acw_regs.vh */
`ifndef ACW_REGS_VH
`define ACW_REGS_VH
`define ACW_WORD_W 64
`define ACW_PRE_W 8
`define ACW_XFER_BITS 72
`define ACW_GAP_MCK 3
`define ACW_PRE_READ 8'h23
`define ACW_PRE_WRITE 8'h22
`define ACW_VOLL_LSB 0
`define ACW_VOLR_LSB 9
`define ACW_BDIR_BIT 18
`define ACW_BLVL_LSB 19
`define ACW_BCOR_LSB 23
`define ACW_TDIR_BIT 25
`define ACW_TLVL_LSB 26
`define ACW_TCOR_LSB 30
`define ACW_DE_LSB 32
`define ACW_CLIP_EN_BIT 34
`define ACW_CLIP_MODE_BIT 35
`define ACW_DITHER_BIT 36
`define ACW_ATTACK_LSB 37
`define ACW_RELEASE_LSB 40
`define ACW_FMT_LSB 44
`define ACW_MIX_LSB 46
`define ACW_HBON_BIT 50
`define ACW_PCOMP_LSB 51
`define ACW_NCOMP_LSB 56
`define ACW_ALP_BIT 61
`define ACW_HSPD_BIT 62
`define ACW_HPWM_BIT 63
`define ACW_VOL_RESET 9'h0FA
`define ACW_VOL_SOFTMUTE 9'h040
`define ACW_VOL_MIN 9'h041
`define ACW_VOL_MAX 9'h130
`define ACW_VOL_ZERO 9'h0FE
`define ACW_ATTACK_RESET 3'h1
`define ACW_RELEASE_RESET 4'hA
`define ACW_MIX_RESET 4'h9
`define ACW_PCOMP_RESET 5'h10
`define ACW_NCOMP_RESET 5'h00
`define ACW_COMP_MAX 5'h10
`define ACW_SPEED_SINGLE 2'h0
`endif

/* src/acw_vol_decode.v */
`timescale 1ns/10ps
`default_nettype none
`include "acw_regs.vh"
module acw_vol_decode (
  input wire clk,
  input wire rst,
  input wire [8:0] code,
  output reg signed [9:0] gain_half_db,
  output reg soft_mute
);
  reg [8:0] clamped;
  always @* begin
    if (code > `ACW_VOL_MAX) begin
      clamped = `ACW_VOL_MAX;
    end else if (code < `ACW_VOL_SOFTMUTE) begin
      clamped = `ACW_VOL_SOFTMUTE;
    end else begin
      clamped = code;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      gain_half_db <= 10'sh3FC;
      soft_mute <= 1'b0;
    end else begin
      // Half-dB steps about 0 dB; soft mute is -95 dB
      gain_half_db <= $signed({1'b0, clamped}) - $signed({1'b0, `ACW_VOL_ZERO});
      soft_mute <= (clamped == `ACW_VOL_SOFTMUTE);
    end
  end
endmodule
`default_nettype wire

/* src/acw_serial_port.v */
`timescale 1ns/10ps
`default_nettype none
`include "acw_regs.vh"
module acw_serial_port (
  input wire clk,
  input wire rst,
  input wire ser_en_n,
  input wire ser_clk,
  input wire ser_din,
  output reg ser_dout,
  output reg ser_doe_n,
  input wire [63:0] word_rd,
  output reg [63:0] word_wr,
  output reg word_wr_stb
);
  reg ser_clk_q;
  reg [6:0] bit_cnt;
  reg [7:0] pre;
  reg [63:0] shift;
  reg is_read;
  wire rise = ser_clk & ~ser_clk_q;
  wire fall = ~ser_clk & ser_clk_q;
  always @(posedge clk) begin
    if (rst) begin
      ser_clk_q <= 1'b0;
      bit_cnt <= 7'h00;
      pre <= 8'h00;
      shift <= 64'h0000000000000000;
      is_read <= 1'b0;
      ser_dout <= 1'b0;
      ser_doe_n <= 1'b1;
      word_wr <= 64'h0000000000000000;
      word_wr_stb <= 1'b0;
    end else begin
      ser_clk_q <= ser_clk;
      word_wr_stb <= 1'b0;
      if (ser_en_n) begin
        bit_cnt <= 7'h00;
        is_read <= 1'b0;
        ser_doe_n <= 1'b1;
      end else if (rise && bit_cnt < 7'h48) begin
        bit_cnt <= bit_cnt + 7'h01;
        if (bit_cnt < 7'h08) begin
          pre <= {pre[6:0], ser_din};
          if (bit_cnt == 7'h07) begin
            is_read <= ({pre[6:0], ser_din} == `ACW_PRE_READ);
            shift <= word_rd;
          end
        end else if (!is_read) begin
          shift <= {shift[62:0], ser_din};
          if (bit_cnt == 7'h47) begin
            word_wr <= {shift[62:0], ser_din};
            word_wr_stb <= (pre == `ACW_PRE_WRITE);
          end
        end
      end else if (fall && is_read && bit_cnt >= 7'h08 && bit_cnt < 7'h48) begin
        // MSB first on falling edges
        ser_doe_n <= 1'b0;
        ser_dout <= shift[63];
        shift <= {shift[62:0], 1'b0};
      end
    end
  end
endmodule
`default_nettype wire

/* test/acw_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module acw_host_model (
  input wire logic clk,
  input wire logic ser_dout,
  input wire logic ser_doe_n,
  output logic ser_en_n,
  output logic ser_clk,
  output wire logic ser_din
);
  logic hd, hoe, junk;
  initial begin
    ser_en_n = 1'b1;
    ser_clk = 1'b0;
    hd = 1'b0;
    hoe = 1'b1;
    junk = 1'b0;
  end
  always @(posedge clk) junk <= ~junk;
  // Shared data wire: device, host, else a toggling float
  assign ser_din = !ser_doe_n ? ser_dout : (hoe ? hd : junk);
  task automatic xfer(input logic [7:0] pre, input logic [63:0] w, output logic [63:0] r);
    logic [71:0] s;
    s = {pre, w};
    r = '0;
    @(posedge clk) ser_en_n <= 1'b0;
    for (int i = 0; i < 72; i++) begin
      hd <= s[71 - i];
      hoe <= (i < 8) || !pre[0];
      repeat (4) @(posedge clk);
      if (i >= 8) r = {r[62:0], ser_dout};
      ser_clk <= 1'b1;
      repeat (2) @(posedge clk);
      ser_clk <= 1'b0;
    end
    repeat (2) @(posedge clk);
    ser_en_n <= 1'b1;
    hoe <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* test/acw_control_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module acw_control_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] speed_mode,
  input wire logic vol_clip,
  input wire logic direct_drive,
  input wire logic bridge_req,
  input wire logic [63:0] amp_control_word,
  input wire logic [1:0] emphasis_filter_select,
  input wire logic deemph_active,
  input wire logic clip_manager_enable,
  input wire logic clip_reduce_volume,
  input wire logic clip_remove_bass,
  input wire logic bridge_drive,
  input wire logic [4:0] pchan_comp,
  input wire logic [4:0] nchan_comp,
  input wire logic [3:0] channel_mix_select,
  input wire logic [1:0] left_src,
  input wire logic [1:0] right_src,
  input wire logic signed [9:0] left_gain
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  emph_decode_a: assert property (emphasis_filter_select == $past(amp_control_word[33:32]))
    else $error("emphasis select wrong");
  emph_speed_a: assert property ($past(speed_mode) != 2'h0 |-> !deemph_active)
    else $error("de-emphasis outside single speed");
  clip_off_a: assert property (!clip_manager_enable |-> !clip_reduce_volume && !clip_remove_bass)
    else $error("clip action while disabled");
  vol_clip_a: assert property ($past(vol_clip) && $past(amp_control_word[34]) |-> clip_reduce_volume)
    else $error("volume clip not reduced");
  bridge_gate_a: assert property (bridge_drive == $past(direct_drive && bridge_req && amp_control_word[50]))
    else $error("bridge drive wrong");
  comp_range_a: assert property (pchan_comp <= 5'h10 && nchan_comp <= 5'h10)
    else $error("compensation out of range");
  mix_straight_a: assert property (channel_mix_select == 4'h9 |-> left_src == 2'h1 && right_src == 2'h2)
    else $error("straight mix wrong");
  gain_step_a: assert property ($past(amp_control_word[8:0]) inside {[9'h041:9'h130]} |->
    left_gain == $signed({1'b0, $past(amp_control_word[8:0])}) - 10'sd254)
    else $error("left gain wrong");
endmodule
`default_nettype wire

/* test/amp_control_word_decode_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module amp_control_word_decode_bench;
  typedef struct {logic [63:0] w; logic [9:0] gl, gr; logic [1:0] ls, rs;} acw_row_t;
  acw_row_t rows [4] = '{
    '{64'hE547_35DE_BF39_FD30, 10'h032, 10'h000, 2'h3, 2'h0},
    '{64'h1001_9000_0004_8240, 10'h342, 10'h343, 2'h2, 2'h1},
    '{64'h0024_0005_0001_F4FA, 10'h3FC, 10'h3FC, 2'h0, 2'h0},
    '{64'h0026_0003_0001_F4FA, 10'h3FC, 10'h3FC, 2'h1, 2'h0}};
  logic clk, rst, vol_clip, bass_clip, direct_drive, bridge_req;
  logic [1:0] speed_mode;
  logic [63:0] w, rd;
  int fail_count = 0;
  int check_count = 0;
  wire ser_en_n, ser_clk, ser_din, ser_dout, ser_doe_n;
  wire [63:0] amp_control_word;
  wire [1:0] emphasis_filter_select, input_format, left_src, right_src, bass_corner_sel;
  wire [1:0] treble_corner_sel;
  wire [3:0] release_rate, channel_mix_select, bass_level, treble_level;
  wire [2:0] attack_rate;
  wire [4:0] pchan_comp, nchan_comp;
  wire signed [9:0] left_gain, right_gain;
  wire deemph_active, clip_manager_enable, clip_manager_mode, clip_reduce_volume;
  wire clip_remove_bass, dither_enable, bridge_drive, auto_lowpower_enable, pwm_high_speed;
  wire pwm_hpwm, left_soft_mute, right_soft_mute, bass_direction, treble_direction;
  acw_control dut (.*);
  acw_host_model hm (.clk(clk), .ser_dout(ser_dout), .ser_doe_n(ser_doe_n),
    .ser_en_n(ser_en_n), .ser_clk(ser_clk), .ser_din(ser_din));
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic test_done;
    if (fail_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    speed_mode = 2'h0;
    vol_clip = 1'b1;
    bass_clip = 1'b1;
    direct_drive = 1'b1;
    bridge_req = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("reset word", 64'h0082_4A20_0001_F4FA, amp_control_word);
    chk("reset out", {10'h3FC, 10'h3FC, 2'h1, 2'h2, 1'b0},
      {left_gain, right_gain, left_src, right_src, bridge_drive});
    for (int i = 0; i < 4; i++) begin
      speed_mode <= i[1:0];
      w = rows[i].w;
      hm.xfer(8'h22, w, rd);
      #1;
      chk("fields", {w[33:32], w[36], w[39:37], w[43:40], w[45:44], w[49:46], w[55:51],
        w[60:56], w[63:61]}, {emphasis_filter_select, dither_enable, attack_rate, release_rate,
        input_format, channel_mix_select, pchan_comp, nchan_comp, pwm_hpwm, pwm_high_speed,
        auto_lowpower_enable});
      chk("tone", {w[31:30], w[29:26], w[25], w[24:23], w[22:19], w[18]},
        {treble_corner_sel, treble_level, treble_direction, bass_corner_sel, bass_level,
        bass_direction});
      chk("datapath", {w[34], w[35], w[34], w[34] & ~w[35], w[50], i == 0 && w[33:32] != 2'h0},
        {clip_manager_enable, clip_manager_mode, clip_reduce_volume, clip_remove_bass,
        bridge_drive, deemph_active});
      chk("volume", {rows[i].gl, rows[i].gr, rows[i].ls, rows[i].rs, w[8:0] <= 9'h040,
        w[17:9] <= 9'h040}, {left_gain, right_gain, left_src, right_src, left_soft_mute,
        right_soft_mute});
      hm.xfer(8'h23, 64'h0, rd);
      chk("readback", w, rd);
    end
    for (logic [8:0] v = 9'h0FA; v <= 9'h0FE; v++) begin
      w = {46'h0, v, v};
      hm.xfer(8'h22, w, rd);
      #1;
      chk("vol step", {10'({1'b0, v} - 10'h0FE), 10'({1'b0, v} - 10'h0FE)},
        {left_gain, right_gain});
    end
    hm.xfer(8'h22, 64'h1FF8_0000_0000_0000, rd);
    hm.xfer(8'h00, 64'hFFFF_FFFF_FFFF_FFFF, rd);
    #1;
    chk("comp clamp", 64'h1080_0000_0000_0000, amp_control_word);
    @(posedge clk) direct_drive <= 1'b0;
    hm.xfer(8'h22, rows[0].w, rd);
    #1;
    chk("bridge off", 64'h0, bridge_drive);
    test_done;
  end
endmodule
bind acw_control acw_control_checker chk (.*);
`default_nettype wire
